// *** src/nvm_pkg.sv ***
package nvm_pkg;
  // ==========================================================
  // Geometry
  localparam int ROW_DATA_BYTES  = 8;
  localparam int ROW_BYTES       = 9;
  localparam int BLK_MAIN_BYTES  = 256;
  localparam int BLK_CHK_BYTES   = 32;
  localparam int NUM_BLOCKS      = 256;
  localparam int NUM_ROWS        = NUM_BLOCKS * BLK_MAIN_BYTES / ROW_DATA_BYTES;
  localparam int EE_ROWS         = 128;
  localparam int EE_ROW_BYTES    = 16;
  localparam int EE_BYTES        = EE_ROWS * EE_ROW_BYTES;
  localparam int CFG_BYTES       = 4;
  localparam int PORT_COUNT      = 8;
  // ==========================================================
  // Register map (byte addresses on the plain register port)
  localparam logic [7:0] REG_DRIVE_LOW   = 8'h00;
  localparam logic [7:0] REG_DRIVE_HIGH  = 8'h01;
  localparam logic [7:0] REG_RESET_PIN   = 8'h02;
  localparam logic [7:0] REG_CLK_ECC_DBG = 8'h03;
  localparam logic [7:0] REG_IRQ_STATUS  = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK    = 8'h05;
  localparam logic [7:0] REG_ERR_ADDR_LO = 8'h06;
  localparam logic [7:0] REG_ERR_ADDR_HI = 8'h07;
  localparam logic [7:0] REG_NVM_STATUS  = 8'h08;
  // ==========================================================
  // Field positions and reset values
  localparam int XRES_BIT       = 7;
  localparam int CHK_EN_BIT     = 2;
  localparam int PHASE_LSB      = 4;
  localparam int DBG_LSB        = 0;
  localparam int IRQ_CORR_BIT   = 0;
  localparam int IRQ_UNCORR_BIT = 1;
  localparam int IRQ_W          = 2;
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'h01;
  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    DRV_HIZ_ANALOG  = 2'h0,
    DRV_HIZ_DIGITAL = 2'h1,
    DRV_PULL_UP     = 2'h2,
    DRV_PULL_DOWN   = 2'h3
  } nvm_drive_t;
  typedef enum logic [1:0] {
    DBG_JTAG5 = 2'h0,
    DBG_JTAG4 = 2'h1,
    DBG_SWD   = 2'h2,
    DBG_OFF   = 2'h3
  } nvm_dbg_t;
  typedef enum logic [1:0] {
    PROT_NONE    = 2'h0,
    PROT_FACTORY = 2'h1,
    PROT_FIELD   = 2'h2,
    PROT_FULL    = 2'h3
  } nvm_prot_t;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  check;
  } nvm_row_t;
  typedef struct packed {
    nvm_drive_t [PORT_COUNT-1:0] port_drive;
    logic                        ext_reset_pin_select;
    nvm_dbg_t                    debug_port_select;
    logic                        check_bits_enable;
    logic [3:0]                  digital_clock_phase_delay;
  } nvm_cfg_t;
endpackage

// *** src/nvm_secded.sv ***
`timescale 1ns/1ps
module nvm_secded
  import nvm_pkg::*;
(
  input  wire logic [63:0] data_in,    // Raw row data
  input  wire logic [7:0]  check_in,   // Stored check byte
  output logic      [63:0] data_out,   // Corrected data
  output logic             err_single, // One bit corrected
  output logic             err_double  // Two bits, not correctable
);
  // ==========================================================
  // Hamming(72,64): data in non power-of-two positions 1..71
  logic [71:1] cw;
  logic [6:0]  syn;
  logic        par;
  logic [71:1] fixed;
  always_comb begin
    int d;
    d = 0;
    cw = '0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        cw[p] = data_in[d];
        d++;
      end
    end
    for (int b = 0; b < 7; b++) begin
      cw[1 << b] = check_in[b];
    end
    syn = '0;
    for (int p = 1; p < 72; p++) begin
      if (cw[p]) syn = syn ^ 7'(p);
    end
    par = (^cw) ^ check_in[7];
    fixed = cw;
    if (par && syn != 7'h00 && syn < 7'd72) fixed[syn] = ~cw[syn];
    err_single = par;
    err_double = !par && (syn != 7'h00);
    d = 0;
    data_out = '0;
    for (int p = 1; p < 72; p++) begin
      if ((p & (p - 1)) != 0) begin
        data_out[d] = fixed[p];
        d++;
      end
    end
  end
endmodule

// *** src/nvm_cfg_latch.sv ***
`timescale 1ns/1ps
module nvm_cfg_latch
  import nvm_pkg::*;
(
  input  wire logic       clk,     // System clock
  input  wire logic       rst,     // Synchronous reset
  input  wire logic       wr,      // Write one latch byte
  input  wire logic [1:0] idx,     // Latch byte index
  input  wire logic [7:0] wdata,   // Write data
  output logic [31:0]     stored,  // Latch array contents
  output nvm_cfg_t        applied  // Configuration taken at reset
);
  // ==========================================================
  // Latch array; values survive reset, applied copy reloads on it
  logic [7:0] arr_r [CFG_BYTES];
  logic       init_r;
  always_ff @(posedge clk) begin
    if (init_r) begin
      if (wr) begin
        arr_r[idx] <= wdata;
      end
    end else begin
      // Power-up: flag not yet set, load factory defaults
      arr_r[0] <= CFG0_RST;
      arr_r[1] <= CFG1_RST;
      arr_r[2] <= CFG2_RST;
      arr_r[3] <= CFG3_RST;
    end
  end
  always_ff @(posedge clk) begin
    init_r <= 1'b1;
  end
  assign stored = {arr_r[3], arr_r[2], arr_r[1], arr_r[0]};
  always_ff @(posedge clk) begin
    if (rst || !init_r) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        applied.port_drive[p] <= nvm_drive_t'(stored[2*p +: 2]);
      end
      applied.ext_reset_pin_select      <= arr_r[2][XRES_BIT];
      applied.debug_port_select         <= nvm_dbg_t'(arr_r[3][DBG_LSB +: 2]);
      applied.check_bits_enable         <= arr_r[3][CHK_EN_BIT];
      applied.digital_clock_phase_delay <= arr_r[3][PHASE_LSB +: 4];
    end
  end
endmodule

// *** src/nvm_top.sv ***
// Contract
// - Flash is read in rows of eight data bytes plus one check byte.
// - Each row read fills an eight-byte instruction buffer serving fetches.
// - Correct single-bit, detect double-bit errors per row; interrupt possible.
// - Code fetches from the check-bit region are refused.
// - Code fetches stall while flash erase or program runs.
// - Flash blocks hold 256 main bytes plus 32 check bytes, 256 blocks.
// - Four protection levels per row, changed only by full erase.
// - Levels gate external and internal reads and writes as tabled.
// - EEPROM reads are direct per byte; writes only via commands.
// - Code fetches continue while an EEPROM write runs.
// - EEPROM is 128 rows of 16 bytes, erased and written whole.
// - No EEPROM error correction and no execution from EEPROM.
// - Four configuration latch bytes are applied at reset.
// - Two-bit per-port field sets reset drive mode of the port.
// - Byte 2 bit 7 selects GPIO or external reset for shared pin.
// - Two-bit field selects debug port; four-wire JTAG default.
// - Check-bit enable latch turns on flash error correction.
// - Four-bit field selects digital clock phase delay after reset.
`timescale 1ns/1ps
module nvm_top
  import nvm_pkg::*;
(
  input  wire logic        clk,          // System clock
  input  wire logic        rst,          // Synchronous reset
  input  wire logic [7:0]  reg_addr,     // Register address
  input  wire logic [7:0]  reg_wdata,    // Register write data
  input  wire logic        reg_wr,       // Register write strobe
  input  wire logic        reg_rd,       // Register read strobe
  output logic      [7:0]  reg_rdata,    // Read data, cycle after strobe
  output logic             irq,          // Level interrupt
  input  wire logic        fetch_req,    // Code fetch request
  input  wire logic [15:0] fetch_addr,   // Code byte address
  input  wire logic        fetch_chk,    // Fetch targets check region
  input  wire logic        fetch_ee,     // Fetch targets EEPROM
  output logic             fetch_ready,  // Fetch accepted this cycle
  output logic             fetch_valid,  // Fetch byte valid
  output logic      [7:0]  fetch_data,   // Fetched byte
  output logic             fetch_fault,  // Fetch refused
  output logic [15:0]      flash_raddr,  // Flash row index
  output logic             flash_rd,     // Flash row read pulse
  input  wire nvm_row_t    flash_row,    // Row returned while read pulse is high
  input  wire logic        prog_busy,    // Flash erase/program running
  input  wire logic        prog_erase_all, // Full erase in progress
  input  wire logic        prot_wr,      // Protection write request
  input  wire logic [12:0] prot_row,     // Row for protection write
  input  wire nvm_prot_t   prot_level,   // Protection level to store
  input  wire logic        acc_req,      // Data access check request
  input  wire logic        acc_ext,      // Access is external
  input  wire logic        acc_write,    // Access is a write
  input  wire logic [12:0] acc_row,      // Row of access
  output logic             acc_allow,    // Access permitted
  input  wire logic        ee_rd,        // EEPROM byte read
  input  wire logic [10:0] ee_raddr,     // EEPROM byte address
  output logic      [7:0]  ee_rdata,     // EEPROM byte, next cycle
  input  wire logic        ee_cmd,       // EEPROM row write command
  input  wire logic [6:0]  ee_cmd_row,   // Row to write
  input  wire logic [127:0] ee_cmd_data, // Row contents
  output logic             ee_busy,      // EEPROM write running
  output nvm_cfg_t         cfg           // Applied configuration
);
  // ==========================================================
  // Configuration latches
  logic [31:0] cfg_stored;
  logic        cfg_wr;
  assign cfg_wr = reg_wr && reg_addr <= REG_CLK_ECC_DBG;
  nvm_cfg_latch u_cfg (
    .clk     (clk),
    .rst     (rst),
    .wr      (cfg_wr),
    .idx     (reg_addr[1:0]),
    .wdata   (reg_wdata),
    .stored  (cfg_stored),
    .applied (cfg)
  );

  // ==========================================================
  // Fetch engine: buffer one row
  typedef enum {F_IDLE, F_READ, F_SERVE} nvm_fst_t;
  nvm_fst_t     fst_r;
  logic [63:0]  buf_r;
  logic [12:0]  buf_row_r;
  logic         buf_ok_r;
  logic [15:0]  pend_addr_r;
  logic [63:0]  corr_data;
  logic         e_single;
  logic         e_double;
  logic         hit;
  logic         refuse;
  nvm_secded u_ecc (
    .data_in    (flash_row.data),
    .check_in   (flash_row.check),
    .data_out   (corr_data),
    .err_single (e_single),
    .err_double (e_double)
  );
  assign refuse      = fetch_chk || fetch_ee;
  assign hit         = buf_ok_r && buf_row_r == fetch_addr[15:3];
  assign fetch_ready = fst_r == F_IDLE && !prog_busy;
  always_ff @(posedge clk) begin
    if (rst) begin
      fst_r       <= F_IDLE;
      pend_addr_r <= 16'h0000;
      flash_rd    <= 1'b0;
      flash_raddr <= 16'h0000;
    end else begin
      flash_rd <= 1'b0;
      case (fst_r)
        F_IDLE: begin
          if (fetch_req && fetch_ready && !refuse) begin
            pend_addr_r <= fetch_addr;
            if (!hit) begin
              flash_rd    <= 1'b1;
              flash_raddr <= {3'h0, fetch_addr[15:3]};
              fst_r       <= F_READ;
            end else begin
              fst_r <= F_SERVE;
            end
          end
        end
        F_READ:  fst_r <= F_SERVE;
        F_SERVE: fst_r <= F_IDLE;
        default: fst_r <= F_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_r     <= 64'h0000_0000_0000_0000;
      buf_row_r <= 13'h0000;
      buf_ok_r  <= 1'b0;
    end else if (prog_busy) begin
      buf_ok_r <= 1'b0;
    end else if (fst_r == F_READ) begin
      buf_r     <= cfg.check_bits_enable ? corr_data : flash_row.data;
      buf_row_r <= pend_addr_r[15:3];
      buf_ok_r  <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      fetch_valid <= 1'b0;
      fetch_data  <= 8'h00;
      fetch_fault <= 1'b0;
    end else begin
      fetch_valid <= fst_r == F_SERVE;
      fetch_data  <= buf_r[8*pend_addr_r[2:0] +: 8];
      fetch_fault <= fetch_req && fetch_ready && refuse;
    end
  end

  // ==========================================================
  // Error status, mask and capture
  logic [IRQ_W-1:0] sts_r;
  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] ev;
  logic [12:0]      err_row_r;
  assign ev[IRQ_CORR_BIT]   = fst_r == F_READ && cfg.check_bits_enable && e_single;
  assign ev[IRQ_UNCORR_BIT] = fst_r == F_READ && cfg.check_bits_enable && e_double;
  always_ff @(posedge clk) begin
    if (rst) begin
      sts_r <= '0;
    end else begin
      sts_r <= (sts_r & ~((reg_wr && reg_addr == REG_IRQ_STATUS) ?
                reg_wdata[IRQ_W-1:0] : '0)) | ev;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      mask_r <= '0;
    end else if (reg_wr && reg_addr == REG_IRQ_MASK) begin
      mask_r <= reg_wdata[IRQ_W-1:0];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      err_row_r <= 13'h0000;
    end else if (|ev) begin
      err_row_r <= pend_addr_r[15:3];
    end
  end
  assign irq = |(sts_r & mask_r);

  // ==========================================================
  // Per-row protection
  nvm_prot_t prot_r [NUM_ROWS];
  logic      erased_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      erased_r <= 1'b0;
    end else if (prog_erase_all) begin
      erased_r <= 1'b1;
    end else if (!prog_busy) begin
      erased_r <= 1'b0;
    end
  end
  generate
    for (genvar r = 0; r < NUM_ROWS; r++) begin : g_prot
      always_ff @(posedge clk) begin
        if (prog_erase_all) begin
          prot_r[r] <= PROT_NONE;
        end else if (prot_wr && erased_r && prot_row == 13'(r)) begin
          prot_r[r] <= prot_level;
        end
      end
    end
  endgenerate
  always_comb begin
    case (prot_r[acc_row])
      PROT_NONE:    acc_allow = acc_req;
      PROT_FACTORY: acc_allow = acc_req && !(acc_ext && !acc_write);
      PROT_FIELD:   acc_allow = acc_req && !acc_ext;
      PROT_FULL:    acc_allow = acc_req && !acc_ext && !acc_write;
      default:      acc_allow = 1'b0;
    endcase
  end

  // ==========================================================
  // EEPROM: direct byte reads, command row writes
  logic [7:0] ee_mem [EE_BYTES];
  logic [4:0] ee_cnt_r;
  logic [6:0] ee_row_r;
  logic [127:0] ee_data_r;
  assign ee_busy = ee_cnt_r != 5'h00;
  always_ff @(posedge clk) begin
    if (rst) begin
      ee_cnt_r  <= 5'h00;
      ee_row_r  <= 7'h00;
      ee_data_r <= '0;
    end else if (ee_cmd && !ee_busy) begin
      ee_cnt_r  <= 5'(EE_ROW_BYTES);
      ee_row_r  <= ee_cmd_row;
      ee_data_r <= ee_cmd_data;
    end else if (ee_busy) begin
      ee_cnt_r <= ee_cnt_r - 5'h01;
    end
  end
  generate
    for (genvar b = 0; b < EE_ROW_BYTES; b++) begin : g_ee
      always_ff @(posedge clk) begin
        if (ee_cnt_r == 5'h01) begin
          ee_mem[{ee_row_r, 4'(b)}] <= ee_data_r[8*b +: 8];
        end
      end
    end
  endgenerate
  always_ff @(posedge clk) begin
    if (rst) begin
      ee_rdata <= 8'h00;
    end else if (ee_rd) begin
      ee_rdata <= ee_mem[ee_raddr];
    end
  end

  // ==========================================================
  // Register read port
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_DRIVE_LOW:   reg_rdata <= cfg_stored[7:0];
        REG_DRIVE_HIGH:  reg_rdata <= cfg_stored[15:8];
        REG_RESET_PIN:   reg_rdata <= cfg_stored[23:16];
        REG_CLK_ECC_DBG: reg_rdata <= cfg_stored[31:24];
        REG_IRQ_STATUS:  reg_rdata <= {6'h00, sts_r};
        REG_IRQ_MASK:    reg_rdata <= {6'h00, mask_r};
        REG_ERR_ADDR_LO: reg_rdata <= err_row_r[7:0];
        REG_ERR_ADDR_HI: reg_rdata <= {3'h0, err_row_r[12:8]};
        REG_NVM_STATUS:  reg_rdata <= {5'h00, ee_busy, prog_busy, buf_ok_r};
        default:         reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// *** verif/nvm_top_properties.sv ***
`timescale 1ns/1ps
module nvm_top_properties
  import nvm_pkg::*;
(
  input wire logic        clk,         // System clock
  input wire logic        rst,         // Synchronous reset
  input wire logic [7:0]  reg_addr,    // Register address
  input wire logic        reg_wr,      // Register write strobe
  input wire logic        irq,         // Level interrupt
  input wire logic        fetch_req,   // Code fetch request
  input wire logic [15:0] fetch_addr,  // Code byte address
  input wire logic        fetch_chk,   // Check region target
  input wire logic        fetch_ee,    // EEPROM target
  input wire logic        fetch_ready, // Fetch accepted
  input wire logic        fetch_valid, // Fetch byte valid
  input wire logic        fetch_fault, // Fetch refused
  input wire logic [15:0] flash_raddr, // Flash row index
  input wire logic        flash_rd,    // Flash row read pulse
  input wire logic        prog_busy,   // Flash erase/program running
  input wire logic        ee_cmd,      // EEPROM row write command
  input wire logic        ee_busy,     // EEPROM write running
  input wire nvm_cfg_t    cfg          // Applied configuration
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Sequences
  sequence s_take;
    fetch_req && fetch_ready && !fetch_chk && !fetch_ee;
  endsequence
  sequence s_ee_take;
    ee_cmd && !ee_busy;
  endsequence
  // ==========================================================
  // Properties
  AST_FETCH_DONE: assert property (s_take |-> ##[2:3] fetch_valid)
    else $error("fetch not served from buffer in time");
  AST_ROW_ADDR: assert property (s_take ##1 flash_rd |->
      flash_raddr == {3'b000, $past(fetch_addr[15:3])})
    else $error("flash row index does not match fetch address");
  AST_CHK_FAULT: assert property (fetch_req && fetch_ready && fetch_chk |=>
      fetch_fault && !fetch_valid)
    else $error("fetch from check region not refused");
  AST_EE_FAULT: assert property (fetch_req && fetch_ready && fetch_ee |=>
      fetch_fault && !fetch_valid)
    else $error("fetch from eeprom not refused");
  AST_STALL: assert property (prog_busy |-> !fetch_ready)
    else $error("fetch accepted during flash programming");
  AST_IRQ_STICKY: assert property (irq && !(reg_wr && (reg_addr == REG_IRQ_STATUS ||
      reg_addr == REG_IRQ_MASK)) |=> irq)
    else $error("interrupt dropped without a clear");
  AST_EE_WRITE: assert property (s_ee_take |=> ee_busy[*8] ##1 ee_busy[*7]
      ##[1:3] !ee_busy)
    else $error("eeprom row write busy length wrong");
  AST_EE_FETCH: assert property (ee_busy && fetch_req && !prog_busy |->
      ##[0:4] fetch_ready)
    else $error("fetch blocked by eeprom write");
  AST_CFG_HOLD: assert property (!$past(rst) |-> $stable(cfg))
    else $error("applied configuration changed outside reset");
endmodule

bind nvm_top nvm_top_properties u_props (.clk, .rst, .reg_addr, .reg_wr, .irq, .fetch_req,
  .fetch_addr, .fetch_chk, .fetch_ee, .fetch_ready, .fetch_valid, .fetch_fault,
  .flash_raddr, .flash_rd, .prog_busy, .ee_cmd, .ee_busy, .cfg);

// *** verif/nvm_flash_model.sv ***
`timescale 1ns/1ps
module nvm_flash_model
  import nvm_pkg::*;
(
  input  wire logic        clk,         // System clock
  input  wire logic        flash_rd,    // Row read pulse
  input  wire logic [15:0] flash_raddr, // Row index
  input  wire logic        ecc_mode,    // Serve flip pattern, zero check byte
  input  wire logic [63:0] flip,        // Data bits of error rows
  output nvm_row_t         flash_row    // Row, valid while read pulse is high
);
  // ==========================================================
  // Row store
  // Row stands while the read pulse is high; the design samples it then
  always_comb begin
    flash_row = '1; // Idle row is all ones, which the decoder takes as a clean codeword
    if (flash_rd) begin
      for (int i = 0; i < ROW_DATA_BYTES; i++) begin
        flash_row.data[8*i +: 8] = ecc_mode ? flip[8*i +: 8] : {3'(i), flash_raddr[4:0]};
      end
      flash_row.check = 8'h00;
    end
  end
endmodule

// *** verif/nvm_top_tb.sv ***
`timescale 1ns/1ps
module nvm_top_tb;
  import nvm_pkg::*;
  logic         clk, rst, reg_wr, reg_rd, irq, fetch_req, fetch_chk, fetch_ee;
  logic         fetch_ready, fetch_valid, fetch_fault, flash_rd, prog_busy, prog_erase_all;
  logic         prot_wr, acc_req, acc_ext, acc_write, acc_allow, ee_rd, ee_cmd, ee_busy;
  logic         ecc_mode, flt;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, fetch_data, ee_rdata, d;
  logic [15:0]  fetch_addr, flash_raddr, a;
  logic [12:0]  prot_row, acc_row;
  logic [10:0]  ee_raddr;
  logic [6:0]   ee_cmd_row;
  logic [127:0] ee_cmd_data, edat;
  logic [63:0]  flip;
  logic [23:0]  exp_cfg;
  logic [7:0]   r [4];
  nvm_row_t     flash_row;
  nvm_prot_t    prot_level;
  nvm_cfg_t     cfg;
  int           n_fail, n_checks, seed, i, j;

  nvm_top dut_u (.*);
  nvm_flash_model fm_u (.clk, .flash_rd, .flash_raddr, .ecc_mode, .flip, .flash_row);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  function automatic logic [7:0] eb(input logic [15:0] x);
    return {x[2:0], x[7:3]};
  endfunction
  function automatic logic alw(input int l, input logic x, w);
    return l == 0 || (l == 1 && !(x && !w)) || (l == 2 && !x) || (l == 3 && !x && !w);
  endfunction
  task automatic complete_run;
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rstp;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, v);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
  endtask
  task automatic fe(input logic [15:0] ad, input logic c, e, output logic [7:0] v,
                    output logic f);
    int n;
    @(posedge clk);
    fetch_addr <= ad;
    fetch_chk <= c;
    fetch_ee <= e;
    fetch_req <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (fetch_ready !== 1'b1 && n < 40);
    @(posedge clk);
    fetch_req <= 1'b0;
    do begin @(negedge clk); n++; end
    while (fetch_valid !== 1'b1 && fetch_fault !== 1'b1 && n < 60);
    if (n >= 60) begin
      chk("fetch_timeout", 0, 1);
      complete_run();
    end
    v = fetch_data;
    f = fetch_fault;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h47ca;
    {rst, reg_wr, reg_rd, fetch_req, fetch_chk, fetch_ee, prog_busy, prog_erase_all} = 8'h80;
    {prot_wr, acc_req, acc_ext, acc_write, ee_rd, ee_cmd, ecc_mode} = '0;
    {reg_addr, reg_wdata, fetch_addr, prot_row, acc_row, ee_raddr, ee_cmd_row} = '0;
    ee_cmd_data = '0;
    flip = '0;
    prot_level = PROT_NONE;
    n_fail = 0;
    n_checks = 0;
    rstp();
    @(negedge clk);
    exp_cfg = {16'h0000, 1'b0, 2'h1, 1'b0, 4'h0};
    chk("cfg_default", exp_cfg, cfg);
    rd(8'h20, d);
    chk("unmapped", 0, d);
    for (i = 0; i < 16; i++) begin
      a = i[0] ? a + 16'h0001 : 16'($random(seed));
      fe(a, 1'b0, 1'b0, d, flt);
      chk("fetch_data", eb(a), d);
    end
    fe(a, 1'b1, 1'b0, d, flt);
    chk("chk_fault", 1, flt);
    fe(a, 1'b0, 1'b1, d, flt);
    chk("ee_fault", 1, flt);
    prog_busy <= 1'b1;
    fork
      fe(a ^ 16'h0100, 1'b0, 1'b0, d, flt);
      begin
        repeat (5) begin @(negedge clk); chk("stall", 0, fetch_ready); end
        prog_busy <= 1'b0;
      end
    join
    chk("stall_data", eb(a ^ 16'h0100), d);
    edat = {$random(seed), $random(seed), $random(seed), $random(seed)};
    @(posedge clk);
    ee_cmd <= 1'b1;
    ee_cmd_row <= 7'($random(seed));
    ee_cmd_data <= edat;
    @(posedge clk);
    ee_cmd <= 1'b0;
    fe(a ^ 16'h0200, 1'b0, 1'b0, d, flt);
    chk("ee_fetch", eb(a ^ 16'h0200), d);
    chk("ee_busy", 1, ee_busy);
    j = 0;
    while (ee_busy !== 1'b0 && j < 40) begin @(negedge clk); j++; end
    chk("ee_done", 0, ee_busy);
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      ee_rd <= 1'b1;
      ee_raddr <= {ee_cmd_row, i[3:0]};
      @(posedge clk);
      ee_rd <= 1'b0;
      @(negedge clk);
      chk("ee_rdata", edat[8*i +: 8], ee_rdata);
    end
    @(posedge clk);
    prog_busy <= 1'b1;
    prog_erase_all <= 1'b1;
    @(posedge clk);
    prog_erase_all <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge clk);
      prot_wr <= 1'b1;
      prot_row <= 13'(i * 7);
      prot_level <= nvm_prot_t'(i);
    end
    @(posedge clk);
    prot_wr <= 1'b0;
    prog_busy <= 1'b0;
    @(posedge clk);
    prot_wr <= 1'b1;
    prot_row <= '0;
    prot_level <= PROT_FULL;
    @(posedge clk);
    prot_wr <= 1'b0;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      acc_req <= 1'b1;
      acc_row <= 13'((i >> 2) * 7);
      acc_ext <= i[1];
      acc_write <= i[0];
      @(negedge clk);
      chk("allow", alw(i >> 2, i[1], i[0]), acc_allow);
    end
    acc_req <= 1'b0;
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 3; j++) r[j] = 8'($random(seed));
      r[3] = {4'($random(seed)), 1'b0, 1'(i == 3), i[1:0]};
      for (j = 0; j < 4; j++) wr(8'(j), r[j]);
      @(negedge clk);
      chk("cfg_hold", exp_cfg, cfg);
      rstp();
      @(negedge clk);
      exp_cfg = {r[1], r[0], r[2][7], r[3][1:0], r[3][2], r[3][7:4]};
      chk("cfg", exp_cfg, cfg);
      rd(8'(i), d);
      chk("latch", r[i], d);
    end
    ecc_mode = 1'b1;
    wr(REG_IRQ_MASK, 8'h03);
    flip = 64'h0000_0000_0001_0000;
    fe(16'h1000, 1'b0, 1'b0, d, flt);
    chk("corrected", 0, d);
    repeat (2) @(negedge clk);
    chk("irq_set", 1, irq);
    flip = 64'h0000_0100_0000_0001;
    fe(16'h2000, 1'b0, 1'b0, d, flt);
    rd(REG_IRQ_STATUS, d);
    chk("status", 2'h3, d[1:0]);
    wr(REG_IRQ_STATUS, 8'h03);
    @(negedge clk);
    chk("irq_clear", 0, irq);
    wr(REG_IRQ_MASK, 8'h00);
    flip = 64'h0000_0000_0000_0800;
    fe(16'h3000, 1'b0, 1'b0, d, flt);
    rd(REG_IRQ_STATUS, d);
    chk("status_masked", 2'h1, d[1:0]);
    chk("irq_masked", 0, irq);
    rd(REG_ERR_ADDR_LO, d);
    chk("err_row_lo", 8'h00, d);
    rd(REG_ERR_ADDR_HI, d);
    chk("err_row_hi", 8'h06, d);
    complete_run();
  end
endmodule
